// >>> design/tmr_pkg.sv
// shared constants and types for the timer/counter with shared prescaler
package tmr_pkg;

	// clock and timing
	localparam int unsigned CLK_PERIOD_NS    = 50;   // hclk, one oscillator period
	localparam int unsigned PHASES_PER_TCY   = 4;    // four phases make one instruction cycle
	localparam int unsigned INHIBIT_TCY      = 2;    // count held off after a count write
	localparam int unsigned INHIBIT_CYC      = INHIBIT_TCY * PHASES_PER_TCY;
	localparam int unsigned ROLL_DELAY_TOSC  = 3;    // flag leads the roll to zero
	localparam int unsigned ROLL_DELAY_NS    = ROLL_DELAY_TOSC * CLK_PERIOD_NS;
	localparam int unsigned ROLL_CYC         = (ROLL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// phase codes of the instruction cycle
	localparam logic [1:0]  PH_SECOND        = 2'h1;
	localparam logic [1:0]  PH_FOURTH        = 2'h3;

	// register indices, byte address is four times the index
	localparam logic [7:0]  IDX_COUNT        = 8'h01;
	localparam logic [7:0]  IDX_INTCTL       = 8'h0B;
	localparam logic [7:0]  IDX_OPTION       = 8'h81;
	localparam logic [7:0]  IDX_CORECTL      = 8'h20;

	// field positions
	localparam int unsigned INT_EN_BIT       = 5;
	localparam int unsigned INT_FLAG_BIT     = 2;
	localparam int unsigned CORE_SLEEP_BIT   = 0;
	localparam int unsigned CORE_WDCLR_BIT   = 1;

	// reset values
	localparam logic [7:0]  OPTION_RST       = 8'hFF;
	localparam logic [7:0]  COUNT_RST        = 8'h00;
	localparam logic [7:0]  COUNT_MAX        = 8'hFF;

	// option register layout, bit 7 first
	typedef struct packed {
		logic       pullup_n;
		logic       int_edge;
		logic       count_source_select;
		logic       source_edge_select;
		logic       prescaler_owner_bit;
		logic [2:0] prescale_rate_field;
	} option_t;

	// captured address phase of an ahb transfer
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] index;
	} addr_phase_t;

	// register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_COUNT,
		SEL_INTCTL,
		SEL_OPTION,
		SEL_CORECTL
	} reg_sel_t;

	// roll-over sequencer, one-hot
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_ROLL = 2'b10
	} roll_state_t;

endpackage : tmr_pkg

// >>> design/shared_prescaler.sv
// eight-bit prescaler counter shared by timer and watchdog
`timescale 1ns/1ps

module shared_prescaler #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// control
	input  wire logic             clear,
	input  wire logic             step,
	// state
	output logic [WIDTH-1:0]      value_r
);
	import tmr_pkg::*;

	logic [WIDTH-1:0] value_nxt;

	// clear wins over step so the first step after a clear counts from zero
	always_comb begin
		value_nxt = value_r;
		if (clear) begin
			value_nxt = '0;
		end else if (step) begin
			value_nxt = value_r + WIDTH'(1);
		end
	end

	// no software path reaches this register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_r <= '0;
		end else begin
			value_r <= value_nxt;
		end
	end

endmodule : shared_prescaler

// >>> design/timer_counter_core.sv
// timer/counter with shared prescaler, ahb-lite register slave
//
// Overview of operation
// RULE1 - source select clear: count every instruction cycle
// RULE2 - count write holds counting two cycles
// RULE3 - source select set: count external pin edges
// RULE4 - edge select: clear rising, set falling
// RULE5 - one prescaler, owner bit picks timer/watchdog
// RULE6 - owner and rate set ratio 1:2..1:256
// RULE7 - rate n: timer 2^(n+1), watchdog 2^n
// RULE8 - eight-bit prescaler, invisible to software
// RULE9 - timer owner: count write clears prescaler
// RULE10 - watchdog owner: watchdog clear clears prescaler
// RULE11 - roll from max to zero sets flag
// RULE12 - enable gates request, flag still sets
// RULE13 - software clears flag before re-enabling
// RULE14 - timer halts in sleep, never wakes
// RULE15 - sample source on second, fourth phase
// RULE16 - unscaled pin: two periods high, low
// RULE17 - pin prescaled by counter, symmetric output
// RULE18 - prescaled pin period over four/ratio
// RULE19 - count follows pin within 3..7 periods
// RULE20 - flag at once, roll three periods later
// RULE21 - timer to watchdog: clear count, watchdog, write
// RULE22 - watchdog to timer: clear watchdog, write option
`timescale 1ns/1ps

module timer_counter_core #(
	parameter int unsigned PRE_WIDTH = 8
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// external count pin, input half only
	input  wire logic        external_count_input,
	// watchdog side
	input  wire logic        wdt_base_tick,
	output logic             wdt_scaled_tick,
	output logic             wdt_clear_pulse,
	// interrupt request to the core
	output logic             overflow_irq
);
	import tmr_pkg::*;

	// decode of a register index, shared by read and write paths
	function automatic reg_sel_t decode(input logic [7:0] idx);
		unique case (idx)
			IDX_COUNT:   decode = SEL_COUNT;
			IDX_INTCTL:  decode = SEL_INTCTL;
			IDX_OPTION:  decode = SEL_OPTION;
			IDX_CORECTL: decode = SEL_CORECTL;
			default:     decode = SEL_NONE;
		endcase
	endfunction : decode

	// true when one more step makes bit k of the value rise
	function automatic logic rises_next(input logic [PRE_WIDTH-1:0] v, input int unsigned k);
		logic [PRE_WIDTH-1:0] low_mask;
		low_mask   = (PRE_WIDTH'(1) << k) - PRE_WIDTH'(1);
		rises_next = ~v[k] && ((v & low_mask) == low_mask);
	endfunction : rises_next

	// bus state
	addr_phase_t         aph_r;
	addr_phase_t         aph_nxt;
	logic [31:0]         hrdata_r;
	logic [31:0]         hrdata_nxt;
	// registers
	option_t             option_r;
	option_t             option_nxt;
	logic [7:0]          count_r;
	logic [7:0]          count_nxt;
	logic                flag_r;
	logic                flag_nxt;
	logic                int_en_r;
	logic                int_en_nxt;
	logic                sleep_r;
	logic                sleep_nxt;
	logic                wdclr_r;
	logic                wdclr_nxt;
	// timing state
	logic [1:0]          phase_r;
	logic [1:0]          phase_nxt;
	logic                pin_prev_r;
	logic                pin_prev_nxt;
	logic                sample_r;
	logic                sample_nxt;
	logic                tick_r;
	logic                tick_nxt;
	logic [3:0]          inhibit_r;
	logic [3:0]          inhibit_nxt;
	roll_state_t         state_r;
	roll_state_t         state_nxt;
	logic [1:0]          roll_cnt_r;
	logic [1:0]          roll_cnt_nxt;
	logic                wdt_out_r;
	logic                wdt_out_nxt;
	// combinational
	logic                wr_en;
	reg_sel_t            wr_sel;
	logic                wr_count;
	logic                timer_owns;
	logic                pin_level;
	logic                pin_edge;
	logic                pre_step;
	logic                pre_clear;
	logic                sync_src;
	logic                sample_now;
	logic                count_tick;
	logic [PRE_WIDTH-1:0] pre_value;

	// zero-wait slave, every answer okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	// data-phase write decode
	assign wr_en    = aph_r.valid && aph_r.write;
	assign wr_sel   = decode(aph_r.index);
	assign wr_count = wr_en && (wr_sel == SEL_COUNT);

	// owner bit clear means the timer holds the prescaler
	assign timer_owns = ~option_r.prescaler_owner_bit; // [RULE5]

	// edge select inverts the pin so a rising edge always counts
	assign pin_level = external_count_input ^ option_r.source_edge_select; // [RULE4]
	assign pin_edge  = pin_level && ~pin_prev_r;

	// prescaler stepping: pin edges, instruction cycles or watchdog ticks
	always_comb begin
		pre_step = 1'b0;
		if (!timer_owns) begin
			pre_step = wdt_base_tick; // watchdog runs on through sleep
		end else if (!sleep_r) begin
			if (option_r.count_source_select) begin
				pre_step = pin_edge; // [RULE17]
			end else begin
				pre_step = (phase_r == PH_FOURTH); // [RULE1]
			end
		end
	end

	// prescaler clearing on count write or watchdog clear
	assign pre_clear = (timer_owns && wr_count)      // [RULE9]
		|| (!timer_owns && wdclr_r);                  // [RULE10]

	shared_prescaler #(
		.WIDTH   (PRE_WIDTH)
	) u_prescaler (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (pre_clear),
		.step    (pre_step),
		.value_r (pre_value) // [RULE8]
	);

	// source seen by the phase sampler
	always_comb begin
		if (timer_owns) begin
			sync_src = pre_value[option_r.prescale_rate_field]; // [RULE6] [RULE7]
		end else if (option_r.count_source_select) begin
			sync_src = pin_level; // [RULE3]
		end else begin
			sync_src = phase_r[1]; // one rise per instruction cycle [RULE1]
		end
	end

	// samples taken only on the second and fourth phase
	assign sample_now = (phase_r == PH_SECOND) || (phase_r == PH_FOURTH); // [RULE15]
	// a write or the hold-off after it swallows ticks
	assign count_tick = tick_r && !sleep_r && (inhibit_r == 4'h0) && !wr_count; // [RULE2] [RULE14]

	// phase, sampler and hold-off
	always_comb begin
		phase_nxt    = phase_r + 2'h1;
		pin_prev_nxt = pin_level;
		sample_nxt   = sample_r;
		tick_nxt     = 1'b0;
		inhibit_nxt  = inhibit_r;
		if (sample_now) begin
			sample_nxt = sync_src;
			tick_nxt   = sync_src && ~sample_r; // rise between samples [RULE19]
		end
		if (wr_count) begin
			inhibit_nxt = 4'(INHIBIT_CYC); // [RULE2]
		end else if (inhibit_r != 4'h0) begin
			inhibit_nxt = inhibit_r - 4'h1;
		end
	end

	// count and overflow sequencing
	always_comb begin
		count_nxt    = count_r;
		state_nxt    = state_r;
		roll_cnt_nxt = roll_cnt_r;
		unique case (state_r)
			ST_RUN: begin
				if (count_tick) begin
					if (count_r == COUNT_MAX) begin
						state_nxt    = ST_ROLL; // flag now, zero later [RULE20]
						roll_cnt_nxt = 2'(ROLL_CYC - 1);
					end else begin
						count_nxt = count_r + 8'h01;
					end
				end
			end
			ST_ROLL: begin
				if (roll_cnt_r == 2'h0) begin
					count_nxt = 8'h00; // [RULE11] [RULE20]
					state_nxt = ST_RUN;
				end else begin
					roll_cnt_nxt = roll_cnt_r - 2'h1;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
		// a software write overrides a pending roll
		if (wr_count) begin
			count_nxt = hwdata[7:0];
			state_nxt = ST_RUN;
		end
	end

	// software registers; the overflow set beats a software clear
	always_comb begin
		option_nxt = option_r;
		flag_nxt   = flag_r;
		int_en_nxt = int_en_r;
		sleep_nxt  = sleep_r;
		wdclr_nxt  = 1'b0;
		if (wr_en) begin
			unique case (wr_sel)
				SEL_OPTION:  option_nxt = option_t'(hwdata[7:0]);
				SEL_INTCTL: begin
					flag_nxt   = hwdata[INT_FLAG_BIT]; // [RULE13]
					int_en_nxt = hwdata[INT_EN_BIT];
				end
				SEL_CORECTL: begin
					sleep_nxt = hwdata[CORE_SLEEP_BIT];
					wdclr_nxt = hwdata[CORE_WDCLR_BIT];
				end
				SEL_COUNT, SEL_NONE: ;
			endcase
		end
		if ((state_r == ST_RUN) && count_tick && (count_r == COUNT_MAX)) begin
			flag_nxt = 1'b1; // [RULE11] [RULE20]
		end
	end

	// bus address phase and read data, registered for the data phase
	always_comb begin
		aph_nxt.valid = hsel && hready && htrans[1];
		aph_nxt.write = hwrite;
		aph_nxt.index = haddr[9:2];
		hrdata_nxt    = hrdata_r;
		if (hsel && hready && htrans[1] && !hwrite) begin
			hrdata_nxt = 32'h0000_0000; // unmapped reads give zero
			unique case (decode(haddr[9:2]))
				SEL_COUNT:   hrdata_nxt[7:0] = count_r;
				SEL_OPTION:  hrdata_nxt[7:0] = option_r;
				SEL_INTCTL: begin
					hrdata_nxt[INT_EN_BIT]   = int_en_r;
					hrdata_nxt[INT_FLAG_BIT] = flag_r;
				end
				SEL_CORECTL: hrdata_nxt[CORE_SLEEP_BIT] = sleep_r;
				SEL_NONE:    ;
			endcase
		end
	end

	// watchdog postscale: ratio 2^n, n zero passes the base tick through
	always_comb begin
		wdt_out_nxt = 1'b0;
		if (!timer_owns) begin
			if (option_r.prescale_rate_field == 3'h0) begin
				wdt_out_nxt = wdt_base_tick; // [RULE7]
			end else begin
				wdt_out_nxt = wdt_base_tick && !wdclr_r
					&& rises_next(pre_value, 32'(option_r.prescale_rate_field) - 1); // [RULE7]
			end
		end else begin
			wdt_out_nxt = wdt_base_tick; // watchdog unscaled while timer owns [RULE5]
		end
	end

	// all state registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_r      <= '0;
			hrdata_r   <= 32'h0000_0000;
			option_r   <= option_t'(OPTION_RST);
			count_r    <= COUNT_RST;
			flag_r     <= 1'b0;
			int_en_r   <= 1'b0;
			sleep_r    <= 1'b0;
			wdclr_r    <= 1'b0;
			phase_r    <= 2'h0;
			pin_prev_r <= 1'b1; // high start: an idle-high source gives no false edge
			sample_r   <= 1'b1; // a tick needs a low sample first after reset
			tick_r     <= 1'b0;
			inhibit_r  <= 4'h0;
			state_r    <= ST_RUN;
			roll_cnt_r <= 2'h0;
			wdt_out_r  <= 1'b0;
		end else begin
			aph_r      <= aph_nxt;
			hrdata_r   <= hrdata_nxt;
			option_r   <= option_nxt;
			count_r    <= count_nxt;
			flag_r     <= flag_nxt;
			int_en_r   <= int_en_nxt;
			sleep_r    <= sleep_nxt;
			wdclr_r    <= wdclr_nxt;
			phase_r    <= phase_nxt;
			pin_prev_r <= pin_prev_nxt;
			sample_r   <= sample_nxt;
			tick_r     <= tick_nxt;
			inhibit_r  <= inhibit_nxt;
			state_r    <= state_nxt;
			roll_cnt_r <= roll_cnt_nxt;
			wdt_out_r  <= wdt_out_nxt;
		end
	end

	// outputs to watchdog and core
	assign wdt_scaled_tick = wdt_out_r;
	assign wdt_clear_pulse = wdclr_r;
	// the request is masked but the flag keeps its state
	assign overflow_irq    = flag_r && int_en_r; // [RULE12]

endmodule : timer_counter_core

// >>> test/timer_counter_sva.sv
// assertion checker for the timer/counter register slave and watchdog hooks
`timescale 1ns/1ps

module timer_counter_sva
	import tmr_pkg::*;
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// watchdog and interrupt
	input wire logic        wdt_base_tick,
	input wire logic        wdt_scaled_tick,
	input wire logic        wdt_clear_pulse,
	input wire logic        overflow_irq
);
	addr_phase_t ap_r;
	logic        en_r;
	logic        own_r;
	logic        dp_wr;
	logic        ic_wr;
	logic        wd_req;
	logic        rd_bad;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// what the current data phase hits
	assign dp_wr  = ap_r.valid & ap_r.write;
	assign ic_wr  = dp_wr & (ap_r.index == IDX_INTCTL);
	assign wd_req = dp_wr & (ap_r.index == IDX_CORECTL) & hwdata[CORE_WDCLR_BIT];
	assign rd_bad = ap_r.valid & !ap_r.write
		& !(ap_r.index inside {IDX_COUNT, IDX_INTCTL, IDX_OPTION, IDX_CORECTL});

	// shadows of the address phase, enable bit and owner bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r  <= '0;
			en_r  <= 1'h0;
			own_r <= 1'h1;
		end else begin
			ap_r  <= '{hsel & hready & htrans[1], hwrite, haddr[9:2]};
			if (ic_wr)
				en_r <= hwdata[INT_EN_BIT];
			if (dp_wr && ap_r.index == IDX_OPTION)
				own_r <= hwdata[3];
		end
	end

	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
	property p_irq_enable;
		overflow_irq |-> en_r;
	endproperty
	a_irq_enable: assert property (p_irq_enable) else $error("irq while masked");
	property p_flag_holds;
		overflow_irq && !ic_wr |=> overflow_irq;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag lost");
	property p_wdclr_follow;
		wd_req |=> wdt_clear_pulse;
	endproperty
	a_wdclr_follow: assert property (p_wdclr_follow) else $error("no clear pulse");
	property p_wdclr_cause;
		wdt_clear_pulse |-> $past(wd_req);
	endproperty
	a_wdclr_cause: assert property (p_wdclr_cause) else $error("stray clear");
	property p_scaled_cause;
		wdt_scaled_tick |-> $past(wdt_base_tick);
	endproperty
	a_scaled_cause: assert property (p_scaled_cause) else $error("stray tick");
	property p_unscaled;
		!own_r && wdt_base_tick |=> wdt_scaled_tick;
	endproperty
	a_unscaled: assert property (p_unscaled) else $error("tick not passed");
	property p_unmapped;
		rd_bad |-> hrdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : timer_counter_sva

// >>> test/count_source_model.sv
// external count source toggling the count pin
`timescale 1ns/1ps

module count_source_model (
	// clock
	input wire logic       hclk,
	// control from the bench
	input wire logic       run,
	input wire logic [3:0] half,
	// count pin
	output logic           external_count_input
);
	logic [3:0] cnt_r = 4'h0;
	logic       lvl_r = 1'h0;

	assign external_count_input = lvl_r;

	// each level held half cycles, never under two; pin stands still when stopped
	always @(posedge hclk) begin
		if (!run)
			cnt_r <= 4'h0;
		else if (cnt_r != 4'h0 && cnt_r >= half - 4'h1) begin
			cnt_r <= 4'h0;
			lvl_r <= ~lvl_r;
		end else
			cnt_r <= cnt_r + 4'h1;
	end
endmodule : count_source_model

// >>> test/tb_timer_counter_with_shared_prescaler.sv
// self-checking bench for the timer/counter with shared prescaler
`timescale 1ns/1ps

module tb_timer_counter_with_shared_prescaler;
	import tmr_pkg::*;
	logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic        run = 1'h0, base_tick = 1'h0, rd_dp = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [3:0]  half = 4'h2;
	logic [63:0] e;
	logic [63:0] exp_q[$];
	wire  logic  hreadyout, hresp, pin, scaled, clr, irq;
	wire  logic [31:0] hrdata;
	int          num_errors = 0, check_count = 0, cyc = 0, n_scaled = 0, k, t;

	always #25 hclk = ~hclk;

	timer_counter_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_count_input(pin),
		.wdt_base_tick(base_tick), .wdt_scaled_tick(scaled), .wdt_clear_pulse(clr),
		.overflow_irq(irq));
	count_source_model src (.hclk(hclk), .run(run), .half(half), .external_count_input(pin));

	task automatic chk(input string what, input logic [31:0] seen, lo, hi);
		check_count++;
		if (((seen >= lo) && (seen <= hi)) !== 1'h1) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h..%0h seen %0h", what, lo, hi, seen);
		end
	endtask : chk

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// one bus transfer; read notes go to the queue
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		// hsel stays up with htrans idle, so back-to-back calls never drive it twice in a step
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'h1, idx, {24'h0, d});
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] lo, hi);
		exp_q.push_back({lo, hi});
		xfer(1'h0, idx, 32'h0);
	endtask : rd

	task automatic pins(input int h, input int halves);
		half <= h[3:0];
		run <= 1'h1;
		repeat (h * halves) @(posedge hclk);
		run <= 1'h0;
	endtask : pins

	task automatic ticks(input int n);
		repeat (n) begin
			base_tick <= 1'h1;
			@(posedge hclk);
			base_tick <= 1'h0;
			repeat (3) @(posedge hclk);
		end
	endtask : ticks

	task automatic irq_is(input logic v);
		@(negedge hclk);
		chk("irq", {31'h0, irq}, {31'h0, v}, {31'h0, v});
		@(posedge hclk);
	endtask : irq_is

	// watcher: oldest read note against the data phase, timeout, tick count
	always @(posedge hclk) begin
		if (rd_dp) begin
			e = exp_q.pop_front();
			chk("read data", hrdata, e[63:32], e[31:0]);
		end
		rd_dp <= hsel & hreadyout & htrans[1] & !hwrite;
		if (scaled === 1'h1)
			n_scaled++;
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		void'($urandom(12214));
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		// reset values, unmapped place
		rd(IDX_OPTION, OPTION_RST, OPTION_RST);
		rd(IDX_COUNT, COUNT_RST, COUNT_RST);
		rd(IDX_INTCTL, 0, 0);
		wr(8'h05, 8'hA5);
		rd(8'h05, 0, 0);
		// timer without prescaler: hold-off, then one count a cycle
		wr(IDX_OPTION, 8'h08);
		t = $urandom % 256;
		wr(IDX_COUNT, t[7:0]);
		repeat (3) rd(IDX_COUNT, t, t);
		wr(IDX_COUNT, 8'h10);
		repeat (399) @(posedge hclk);
		rd(IDX_COUNT, 8'h70, 8'h74);
		// prescaler to the timer at each rate; window holds three counts
		wr(IDX_CORECTL, 8'h02);
		for (int n = 0; n < 8; n++) begin
			t = 4 << (n + 1);
			wr(IDX_OPTION, {5'h00, n[2:0]});
			wr(IDX_COUNT, 8'h00);
			repeat (3 * t + t / 2 - 1) @(posedge hclk);
			rd(IDX_COUNT, (7 * t / 2 - 16) / t, 3);
		end
		// counter mode, rising then falling; odd halves give one extra counted edge
		wr(IDX_COUNT, 8'h00);
		wr(IDX_CORECTL, 8'h02);
		for (int s = 0; s < 2; s++) begin
			k = 3 + $urandom % 5;
			wr(IDX_OPTION, {2'h0, 1'h1, s[0], 1'h1, 3'h0});
			wr(IDX_COUNT, 8'h00);
			repeat (10) @(posedge hclk);
			pins(2 + $urandom % 4, 2 * k + 1);
			repeat (8) @(posedge hclk);
			rd(IDX_COUNT, k + 1, k + 1);
		end
		// pin through the prescaler at 1:4
		wr(IDX_CORECTL, 8'h02);
		wr(IDX_OPTION, 8'h21);
		wr(IDX_COUNT, 8'h00);
		repeat (10) @(posedge hclk);
		pins(2, 32);
		repeat (8) @(posedge hclk);
		rd(IDX_COUNT, 4, 4);
		// overflow masked, enabled, cleared, and flag ahead of the roll
		wr(IDX_COUNT, 8'h00);
		wr(IDX_CORECTL, 8'h02);
		wr(IDX_OPTION, 8'h08);
		wr(IDX_COUNT, 8'hFE);
		repeat (30) @(posedge hclk);
		rd(IDX_INTCTL, 8'h04, 8'h04);
		irq_is(1'h0);
		wr(IDX_INTCTL, 8'h24);
		irq_is(1'h1);
		wr(IDX_INTCTL, 8'h20);
		irq_is(1'h0);
		wr(IDX_COUNT, 8'hFE);
		t = 0;
		do begin
			@(negedge hclk);
			t++;
		end while (irq !== 1'h1 && t < 40);
		@(posedge hclk);
		rd(IDX_COUNT, 8'hFF, 8'hFF);
		wr(IDX_INTCTL, 8'h00);
		// sleep stops the count
		wr(IDX_CORECTL, 8'h01);
		wr(IDX_COUNT, 8'h20);
		repeat (100) @(posedge hclk);
		rd(IDX_COUNT, 8'h20, 8'h20);
		wr(IDX_CORECTL, 8'h00);
		// watchdog postscale 1:4 after a clear, then unscaled under the timer
		wr(IDX_COUNT, 8'h00);
		wr(IDX_CORECTL, 8'h02);
		wr(IDX_OPTION, 8'h0A);
		t = n_scaled;
		ticks(16);
		chk("postscale", n_scaled - t, 4, 4);
		wr(IDX_CORECTL, 8'h02);
		wr(IDX_OPTION, 8'h00);
		t = n_scaled;
		ticks(3);
		chk("unscaled", n_scaled - t, 3, 3);
		repeat (4) @(posedge hclk);
		conclude();
	end
endmodule : tb_timer_counter_with_shared_prescaler

bind timer_counter_core timer_counter_sva chk_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.wdt_base_tick(wdt_base_tick), .wdt_scaled_tick(wdt_scaled_tick),
	.wdt_clear_pulse(wdt_clear_pulse), .overflow_irq(overflow_irq));
